// [kbc_top.sv]
// Keyboard-console attachment: key capture, sense, lights, start/stop
`timescale 1ns/1ps
`include "kbc_consts.svh"
module kbc_top #(
  parameter int CMD_KEYS = 16,                        // Command keys fitted
  parameter int TYPA_CYC = `KBC_TYPA_CYC              // Typamatic repeat cycles
) (
  input  wire logic                core_clk,          // 10 MHz clock
  input  wire logic                arst_n,            // Async reset, low
  input  wire logic                ce,                // Clock enable
  input  wire logic [4:0]          avs_address,       // Byte address
  input  wire logic                avs_read,          // Read strobe
  input  wire logic                avs_write,         // Write strobe
  input  wire logic [31:0]         avs_writedata,     // Write data
  output logic      [31:0]         avs_readdata,      // Read data
  output logic                     avs_waitrequest,   // Stall
  input  wire logic                key_press_pin,     // A key is down
  input  wire logic                key_deep_pin,      // Second depression level
  input  wire logic                key_shift_pin,     // Shift held
  input  wire logic [1:0]          key_group_pin,     // Key group
  input  wire logic [7:0]          key_code_lo_pin,   // Lower-shift code
  input  wire logic [7:0]          key_code_up_pin,   // Upper-shift code
  input  wire logic                inquiry_pin,       // Inquiry switch on
  input  wire logic                stop_sw_pin,       // Start/stop at stop
  input  wire logic                cpu_op_end,        // Operation ends
  input  wire logic                io_busy,           // I/O transfer running
  output logic                     irq_lvl1,          // Level 1 request
  output logic                     cpu_halt,          // Halt processor
  output logic                     kb_ready_light,    // Keyboard ready
  output logic                     stop_light,        // Stop light
  output logic [8:0]               halt_lights,       // Halt code lights
  output logic [7:0]               field_lights,      // Field/operation lights
  output logic [CMD_KEYS-1:0]      cmd_lights         // Command key lights
);
  import kbc_pkg::*;

  // ------------------------------------------------------------
  // Pin synchronisation
  // ------------------------------------------------------------
  logic [22:0] pins_s;                       // Synchronised pin bundle
  logic        press_s, deep_s, shift_s;     // Key levels
  logic        inq_s, stop_s;                // Switch levels
  logic [7:0]  lo_s, up_s;                   // Codes
  kbc_grp_e    grp_s;                        // Group

  kbc_sync #(.W(23)) u_sync (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .ce       (ce),
    .pin_in   ({key_press_pin, key_deep_pin, key_shift_pin, key_group_pin,
                key_code_lo_pin, key_code_up_pin, inquiry_pin, stop_sw_pin}),
    .sync_out (pins_s)
  );

  // Codes are held steady by the keyboard before the press level rises
  assign {press_s, deep_s, shift_s} = pins_s[22:20];
  assign grp_s  = kbc_grp_e'(pins_s[19:18]);
  assign lo_s   = pins_s[17:10];
  assign up_s   = pins_s[9:2];
  assign inq_s  = pins_s[1];
  assign stop_s = pins_s[0];

  // ------------------------------------------------------------
  // Encoding
  // ------------------------------------------------------------
  logic        press_d_r, inq_d_r;           // Previous levels
  logic        press_rise, inq_rise;         // New press, new inquiry
  logic [7:0]  enc_status, enc_data;         // Encoded bytes
  logic        enc_valid, enc_typa;          // Encoder flags

  assign press_rise = press_s && !press_d_r;
  assign inq_rise   = inq_s && !inq_d_r;

  kbc_encoder #(.CMD_KEYS(CMD_KEYS)) u_enc (
    .group    (grp_s),
    .code_lo  (lo_s),
    .code_up  (up_s),
    .shift    (shift_s),
    .inquiry  (inq_rise),
    .status   (enc_status),
    .data     (enc_data),
    .valid    (enc_valid),
    .typa_key (enc_typa)
  );

  // ------------------------------------------------------------
  // Avalon slave: one wait cycle, then the answer edge
  // ------------------------------------------------------------
  logic        bus_req;                      // Request present
  logic        bus_take;                     // Edge where access takes effect
  logic        wr_start, wr_field, wr_on, wr_off, wr_halt;  // Write decodes
  logic        rd_sense;                     // Sense read taken
  logic [31:0] rd_mux;                       // Read value

  assign bus_req  = avs_read || avs_write;
  assign bus_take = bus_req && !avs_waitrequest;
  assign wr_start = bus_take && avs_write && (avs_address == `KBC_OFS_START);
  assign wr_field = bus_take && avs_write && (avs_address == `KBC_OFS_FIELD);
  assign wr_on    = bus_take && avs_write && (avs_address == `KBC_OFS_CMD_ON);
  assign wr_off   = bus_take && avs_write && (avs_address == `KBC_OFS_CMD_OFF);
  assign wr_halt  = bus_take && avs_write && (avs_address == `KBC_OFS_HALT);
  assign rd_sense = bus_take && avs_read && (avs_address == `KBC_OFS_SENSE);

  // Waitrequest drops for exactly one cycle per request
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      avs_waitrequest <= 1'b1;
    else if (ce)
      avs_waitrequest <= avs_waitrequest ? !bus_req : 1'b1;
  end

  // ------------------------------------------------------------
  // Keyboard state
  // ------------------------------------------------------------
  logic        int_en_r;                     // Level 1 interrupts enabled
  logic        unlock_r;                     // Keys unlocked
  logic        pend_r;                       // Byte pair waiting
  logic        sense_ptr_r;                  // 0: status next, 1: data next
  logic [7:0]  status_r, data_r;             // Held byte pair
  logic [$clog2(TYPA_CYC+1)-1:0] typa_cnt_r; // Repeat timer
  logic        typa_due;                     // Repeat interval elapsed
  logic        hold_typa_r;                  // Held key is tab/backspace
  logic        key_take, inq_take, rep_take, capture;  // Capture causes

  assign typa_due = (typa_cnt_r == ($bits(typa_cnt_r))'(TYPA_CYC));
  assign key_take = press_rise && enc_valid && int_en_r && unlock_r && !pend_r;
  assign inq_take = inq_rise && int_en_r && !pend_r;
  assign rep_take = press_s && deep_s && hold_typa_r && typa_due &&
                    int_en_r && unlock_r && !pend_r;
  assign capture  = key_take || inq_take || rep_take;

  // Edge detect history
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      press_d_r <= 1'b0;
      inq_d_r   <= 1'b0;
    end
    else if (ce)
    begin
      press_d_r <= press_s;
      inq_d_r   <= inq_s;
    end
  end

  // Repeat timer restarts at each capture and on release
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      typa_cnt_r  <= '0;
      hold_typa_r <= 1'b0;
    end
    else if (ce)
    begin
      if (key_take)
        hold_typa_r <= enc_typa;
      else if (!press_s)
        hold_typa_r <= 1'b0;
      if (!press_s || capture)
        typa_cnt_r <= '0;
      else if (!typa_due)
        typa_cnt_r <= typa_cnt_r + 1'b1;
    end
  end

  // Start I/O and capture; a capture wins over the restore clear
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      int_en_r <= 1'b0;
      unlock_r <= 1'b0;
      pend_r   <= 1'b0;
    end
    else if (ce)
    begin
      if (wr_start)
      begin
        int_en_r <= avs_writedata[`KBC_START_INTEN];
        if (avs_writedata[`KBC_START_UNLOCK])
        begin
          unlock_r <= 1'b1;
          pend_r   <= 1'b0;
        end
      end
      if (capture)
      begin
        pend_r   <= 1'b1;
        unlock_r <= 1'b0;
      end
    end
  end

  // Byte pair and sense order
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      status_r    <= `KBC_RST_BYTE;
      data_r      <= `KBC_RST_BYTE;
      sense_ptr_r <= 1'b0;
    end
    else if (ce)
    begin
      if (capture)
      begin
        status_r    <= enc_status;
        data_r      <= enc_data;
        sense_ptr_r <= 1'b0;
      end
      else if (rd_sense)
        sense_ptr_r <= !sense_ptr_r;
    end
  end

  // Request and ready light are registered outputs
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      irq_lvl1       <= 1'b0;
      kb_ready_light <= 1'b0;
    end
    else if (ce)
    begin
      irq_lvl1       <= pend_r && int_en_r;
      kb_ready_light <= unlock_r && int_en_r;
    end
  end

  // ------------------------------------------------------------
  // Console lights under program control
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      field_lights <= '0;
      cmd_lights   <= '0;
    end
    else if (ce)
    begin
      if (wr_field)
        field_lights <= avs_writedata[7:0];
      if (wr_on)
        cmd_lights <= cmd_lights | avs_writedata[CMD_KEYS-1:0];
      else if (wr_off)
        cmd_lights <= cmd_lights & ~avs_writedata[CMD_KEYS-1:0];
    end
  end

  // ------------------------------------------------------------
  // Start/stop sequencing
  // ------------------------------------------------------------
  kbc_run_e run_r;                           // Run state

  // Halt waits for operation end with no I/O moving
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      run_r       <= KBC_RUN;
      cpu_halt    <= 1'b0;
      stop_light  <= 1'b0;
      halt_lights <= '0;
    end
    else if (ce)
    begin
      if (wr_halt)
        halt_lights <= avs_writedata[8:0];
      case (run_r)
        KBC_RUN:
          if (stop_s)
            run_r <= KBC_DRAIN;
        KBC_DRAIN:
          if (!stop_s)
            run_r <= KBC_RUN;
          else if (cpu_op_end && !io_busy)
          begin
            run_r      <= KBC_HALTED;
            cpu_halt   <= 1'b1;
            stop_light <= 1'b1;
          end
        KBC_HALTED:
          if (!stop_s)
          begin
            run_r       <= KBC_RUN;
            cpu_halt    <= 1'b0;
            stop_light  <= 1'b0;
            halt_lights <= '0;
          end
        default:
          run_r <= KBC_RUN;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Read mux, loaded as waitrequest drops
  // ------------------------------------------------------------
  always_comb
  begin
    rd_mux = '0;
    case (avs_address)
      `KBC_OFS_SENSE: rd_mux = {24'h000000, sense_ptr_r ? data_r : status_r};
      `KBC_OFS_FIELD: rd_mux = {24'h000000, field_lights};
      `KBC_OFS_CMD_ON: rd_mux = 32'(cmd_lights);
      `KBC_OFS_HALT:  rd_mux = {22'h000000, stop_light, halt_lights};
      `KBC_OFS_STATE: rd_mux = {27'h0000000, cpu_halt, sense_ptr_r, pend_r,
                                unlock_r, int_en_r};
      default:        rd_mux = '0;
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      avs_readdata <= '0;
    else if (ce && avs_waitrequest && avs_read)
      avs_readdata <= rd_mux;
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  sequence s_capture;
    ce && capture;
  endsequence
  // Status read, two quiet edges, then the data read of the same pair
  sequence s_sense_twice;
    ce && rd_sense && !capture && !sense_ptr_r ##1 !capture ##1 !capture
      ##1 ce && rd_sense && !capture;
  endsequence

  chk_capture_raises_req: assert property (
    s_capture ##1 (ce && int_en_r && !wr_start) |=> irq_lvl1)
    else $error("capture did not raise request");
  chk_locked_no_take: assert property (ce && !unlock_r && !inq_rise |=> !$rose(pend_r))
    else $error("locked keyboard accepted key");
  // A capture on the load edge would replace the bytes under the read
  chk_sense_order: assert property (
    ce && rd_sense && !capture && !$past(capture) && !sense_ptr_r |=>
      sense_ptr_r && avs_readdata[7:0] == status_r)
    else $error("sense order not status first");
  chk_two_sense_wrap: assert property (s_sense_twice |=> !sense_ptr_r)
    else $error("sense pointer did not wrap");
  chk_capture_locks: assert property (s_capture |=> pend_r && !unlock_r)
    else $error("capture did not lock keys");
  chk_inquiry_level: assert property (ce && inq_take |=>
    status_r == `KBC_ST_FUNC && data_r == `KBC_CODE_INQUIRY)
    else $error("inquiry bytes wrong");
  chk_halt_no_io: assert property (ce && $rose(cpu_halt) |-> !$past(io_busy))
    else $error("halt during I/O transfer");
  chk_start_clears: assert property (ce && run_r == KBC_HALTED && !stop_s |=>
    halt_lights == '0 && !stop_light)
    else $error("start did not clear halt lights");
  chk_cmd_off: assert property (ce && wr_off && !wr_on |=>
    (32'(cmd_lights) & $past(avs_writedata)) == '0)
    else $error("command light not cleared");
endmodule : kbc_top

// [kbc_consts.svh]
// Constants for the keyboard-console encoder: offsets, codes, timing
//
// Contract
// - Each non-shift key stores bytes, raises request
// - Bytes leave only on a sense read
// - Character keys give status 0100 0000
// - Extension keys give bit 4 status
// - Function keys give status 0001 0000
// - Command keys set status bit 2
// - Held tab/backspace second level repeats bytes
// - Backspace, return, space use their function codes
// - Inquiry switch acts as function key 0001 0001
// - Shift only selects upper codes, no request
// - Eight command keys, sixteen with option
// - Eight field lights, light 8 lowest bit
// - Command key lights set or cleared by program
// - Stop light and nine halt lights
// - Stop halts after operation; start clears, resumes
// - In-flight I/O transfer completes before halting
// - Keyboard requests on interrupt level one
// - Sense gives status first, data second
`ifndef KBC_CONSTS_SVH
`define KBC_CONSTS_SVH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define KBC_OFS_START     5'h00
`define KBC_OFS_SENSE     5'h04
`define KBC_OFS_FIELD     5'h08
`define KBC_OFS_CMD_ON    5'h0c
`define KBC_OFS_CMD_OFF   5'h10
`define KBC_OFS_HALT      5'h14
`define KBC_OFS_STATE     5'h18

// ------------------------------------------------------------
// Field positions in the start I/O word
// ------------------------------------------------------------
`define KBC_START_INTEN   0
`define KBC_START_UNLOCK  1

// ------------------------------------------------------------
// Status and data bytes
// ------------------------------------------------------------
`define KBC_ST_CHAR       8'h40
`define KBC_ST_CMD        8'h20
`define KBC_ST_FUNC       8'h10
`define KBC_ST_EXT        8'h08
`define KBC_CODE_INQUIRY  8'h11
`define KBC_CODE_TAB      8'h05
`define KBC_CODE_BKSP     8'h16
`define KBC_RST_BYTE      8'h00

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define KBC_CLK_NS        100
`define KBC_TYPA_US       100000
`define KBC_TYPA_CYC      ((`KBC_TYPA_US * 1000) / `KBC_CLK_NS)

`endif

// [kbc_pkg.sv]
// Types shared by the keyboard-console encoder files
package kbc_pkg;

  // Key group reported by the keyboard along with each press
  typedef enum logic [1:0] {
    KBC_GRP_CHAR,
    KBC_GRP_FUNC,
    KBC_GRP_CMD,
    KBC_GRP_EXT
  } kbc_grp_e;

  // Start/stop sequencing
  typedef enum logic [1:0] {
    KBC_RUN,
    KBC_DRAIN,
    KBC_HALTED
  } kbc_run_e;

endpackage : kbc_pkg

// [kbc_sync.sv]
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module kbc_sync #(
  parameter int W = 1                   // Width of the bundle
) (
  input  wire logic         core_clk,   // Core clock
  input  wire logic         arst_n,     // Async reset, low active
  input  wire logic         ce,         // Clock enable
  input  wire logic [W-1:0] pin_in,     // Asynchronous pins
  output logic      [W-1:0] sync_out    // Synchronised copy
);
  logic [W-1:0] meta_r;                 // First stage, read only by second

  // ------------------------------------------------------------
  // Two stages, nothing taps the first one
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      meta_r   <= '0;
      sync_out <= '0;
    end
    else if (ce)
    begin
      meta_r   <= pin_in;
      sync_out <= meta_r;
    end
  end
endmodule : kbc_sync

// [kbc_encoder.sv]
// Key classifier: status byte and data byte for one keystroke
`timescale 1ns/1ps
`include "kbc_consts.svh"
module kbc_encoder #(
  parameter int CMD_KEYS = 16                // 8 standard, 16 with option
) (
  input  kbc_pkg::kbc_grp_e group,           // Key group from keyboard
  input  wire logic [7:0]   code_lo,         // Lower-shift weighted code
  input  wire logic [7:0]   code_up,         // Upper-shift weighted code
  input  wire logic         shift,           // Either shift key held
  input  wire logic         inquiry,         // Inquiry switch is the source
  output logic [7:0]        status,          // Status byte
  output logic [7:0]        data,            // Data byte
  output logic              valid,           // Key is fitted and encodable
  output logic              typa_key         // Tab or backspace
);
  import kbc_pkg::*;

  // ------------------------------------------------------------
  // Classification
  // ------------------------------------------------------------
  always_comb
  begin
    data     = shift ? code_up : code_lo;
    valid    = 1'b1;
    status   = `KBC_ST_CHAR;
    if (inquiry)
    begin
      status = `KBC_ST_FUNC;
      data   = `KBC_CODE_INQUIRY;
    end
    else
    begin
      case (group)
        KBC_GRP_CHAR: status = `KBC_ST_CHAR;
        KBC_GRP_FUNC: status = `KBC_ST_FUNC;
        KBC_GRP_CMD:
        begin
          status = `KBC_ST_CMD;
          data   = code_lo;
          valid  = (code_lo != 8'h00) && (code_lo <= 8'(CMD_KEYS));
        end
        KBC_GRP_EXT:  status = `KBC_ST_EXT;
        default:      status = `KBC_ST_CHAR;
      endcase
    end
    // Only these two function keys have a repeating second level
    typa_key = !inquiry && (group == KBC_GRP_FUNC) &&
               ((data == `KBC_CODE_TAB) || (data == `KBC_CODE_BKSP));
  end
endmodule : kbc_encoder

// [kbc_keys.sv]
// Keyboard model: presents key pins with codes settled before press
`timescale 1ns/1ps
module kbc_keys (
  input  wire logic core_clk, // Core clock
  output logic       press,    // Key down
  output logic       deep,     // Second level
  output logic       shift,    // Shift held
  output logic [1:0] grp,      // Key group
  output logic [7:0] lo,       // Lower code
  output logic [7:0] up        // Upper code
);
  initial {press, deep, shift, grp, lo, up} = '0;
  // Codes settle three clocks before the press edge
  task automatic hit(input logic [1:0] g, input logic [7:0] l, u, input logic s, d);
    @(posedge core_clk);
    grp <= g; lo <= l; up <= u; shift <= s; deep <= d;
    repeat (3) @(posedge core_clk);
    press <= 1'b1;
  endtask : hit
  // Released lines show the inverse so stale codes cannot pass
  task automatic lift();
    @(posedge core_clk);
    press <= 1'b0; deep <= 1'b0; shift <= 1'b0; lo <= ~lo; up <= ~up;
  endtask : lift
endmodule : kbc_keys

// [kbc_top_tb.sv]
// Self-checking bench for the keyboard-console attachment
`timescale 1ns/1ps
`include "kbc_consts.svh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fail_count++; \
  $display("Error %0t: got %h want %h", $time, a, b); end end
module kbc_top_tb;
  import kbc_pkg::*;
  // ----------------------------------------------------------
  // Signals
  // ----------------------------------------------------------
  localparam int TYPA = 20;  // Short repeat interval keeps the run brief
  typedef struct packed {
    logic [1:0] g; logic [7:0] lo; logic [7:0] up; logic sh; logic [7:0] st; logic [7:0] dt;
  } kbc_row_s;
  logic core_clk = 0, arst_n = 0, rd = 0, wr = 0, stop_sw = 0, op_end = 0, busy = 0, inq = 0;
  logic [4:0] adr = '0;
  logic [31:0] wd = '0, rdata, q;
  logic wrq, irq, halt, kbr, stl, press, deep, shift;
  logic [8:0] hl;
  logic [7:0] fl, lo, up;
  logic [15:0] cl;
  logic [1:0] grp;
  int fail_count = 0, tests_run = 0;
  // Ordinary keys: group, codes, shift, expected status and data
  kbc_row_s rows [9] = '{'{0, 8'h0a, 8'h0a, 0, 8'h40, 8'h0a}, '{0, 8'h02, 8'h12, 1, 8'h40, 8'h12},
    '{1, 8'h16, 8'h16, 0, 8'h10, 8'h16}, '{1, 8'h15, 8'h15, 0, 8'h10, 8'h15},
    '{1, 8'h40, 8'h40, 0, 8'h10, 8'h40}, '{3, 8'h01, 8'h01, 0, 8'h08, 8'h01},
    '{3, 8'h02, 8'h02, 0, 8'h08, 8'h02}, '{2, 8'h01, 8'h01, 0, 8'h20, 8'h01},
    '{2, 8'h10, 8'h10, 0, 8'h20, 8'h10}};

  always #50 core_clk = ~core_clk;

  kbc_top #(.CMD_KEYS(16), .TYPA_CYC(TYPA)) kbc_top_inst (.core_clk(core_clk), .arst_n(arst_n),
    .ce(1'b1), .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
    .avs_readdata(rdata), .avs_waitrequest(wrq), .key_press_pin(press), .key_deep_pin(deep),
    .key_shift_pin(shift), .key_group_pin(grp), .key_code_lo_pin(lo), .key_code_up_pin(up),
    .inquiry_pin(inq), .stop_sw_pin(stop_sw), .cpu_op_end(op_end), .io_busy(busy),
    .irq_lvl1(irq), .cpu_halt(halt), .kb_ready_light(kbr), .stop_light(stl),
    .halt_lights(hl), .field_lights(fl), .cmd_lights(cl));
  kbc_keys kbc_keys_inst (.core_clk(core_clk), .press(press), .deep(deep), .shift(shift),
    .grp(grp), .lo(lo), .up(up));

  // ----------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------
  // One bus access, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    adr <= a; wr <= w; rd <= !w; wd <= d;
    do begin @(posedge core_clk); n++; end while (wrq !== 1'b0 && n < 50);
    q = rdata;
    if (n >= 50) begin fail_count++; $display("Error %0t: bus stall", $time); end
    rd <= 1'b0; wr <= 1'b0;
  endtask : bus
  // Two sense reads: status then data
  task automatic sense(input logic [7:0] st, dt);
    bus(1'b0, `KBC_OFS_SENSE, 32'h0); `CHK(q, {24'h0, st})
    bus(1'b0, `KBC_OFS_SENSE, 32'h0); `CHK(q, {24'h0, dt})
  endtask : sense
  // Bounded wait for the request line to reach a level
  task automatic await(input logic want, input int lim);
    int n;
    n = 0;
    while (irq !== want && n < lim) begin @(posedge core_clk); n++; end
    `CHK(irq, want)
  endtask : await
  task automatic restore();
    bus(1'b1, `KBC_OFS_START, 32'h3);
  endtask : restore
  task automatic final_report();
    $display("Checks %0d, errors %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : final_report

  // ----------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------
  initial
  begin
    repeat (3) @(posedge core_clk);
    `CHK({wrq, irq, halt, kbr, stl, hl, fl, cl}, 38'h20_0000_0000)
    arst_n <= 1'b1;
    // keys dead before the first start I/O
    kbc_keys_inst.hit(2'h0, 8'h0a, 8'h0a, 1'b0, 1'b0);
    repeat (10) @(posedge core_clk);
    `CHK(irq, 1'b0)
    kbc_keys_inst.lift();
    restore();
    bus(1'b0, `KBC_OFS_STATE, 32'h0); `CHK(q, 32'h3)
    `CHK(kbr, 1'b1)
    foreach (rows[i])
    begin
      kbc_keys_inst.hit(rows[i].g, rows[i].lo, rows[i].up, rows[i].sh, 1'b0);
      await(1'b1, 10);
      sense(rows[i].st, rows[i].dt);
      kbc_keys_inst.lift();
      restore();
      await(1'b0, 5);
    end
    // second key while pending is lost
    kbc_keys_inst.hit(2'h0, 8'h24, 8'h24, 1'b0, 1'b0);
    await(1'b1, 10);
    kbc_keys_inst.lift();
    kbc_keys_inst.hit(2'h0, 8'h2a, 8'h2a, 1'b0, 1'b0);
    sense(8'h40, 8'h24);
    kbc_keys_inst.lift();
    restore();
    repeat (10) @(posedge core_clk);
    `CHK(irq, 1'b0)
    // Unfitted command code zero is ignored
    kbc_keys_inst.hit(2'h2, 8'h00, 8'h00, 1'b0, 1'b0);
    repeat (10) @(posedge core_clk);
    `CHK(irq, 1'b0)
    kbc_keys_inst.lift();
    // held tab at second level repeats
    kbc_keys_inst.hit(2'h1, 8'h05, 8'h05, 1'b0, 1'b1);
    await(1'b1, 10);
    sense(8'h10, 8'h05);
    restore();
    await(1'b0, 5);
    await(1'b1, TYPA + 10);
    sense(8'h10, 8'h05);
    kbc_keys_inst.lift();
    restore();
    bus(1'b1, `KBC_OFS_START, 32'h1);
    @(posedge core_clk);
    inq <= 1'b1;
    await(1'b1, 10);
    sense(8'h10, 8'h11);
    inq <= 1'b0;
    restore();
    // Light groups under program control
    bus(1'b1, `KBC_OFS_FIELD, 32'h40);
    bus(1'b1, `KBC_OFS_CMD_ON, 32'h8001);
    bus(1'b1, `KBC_OFS_CMD_OFF, 32'h0001);
    @(posedge core_clk);
    `CHK(fl, 8'h40)
    `CHK(cl, 16'h8000)
    bus(1'b1, `KBC_OFS_HALT, 32'h1ff);
    bus(1'b0, `KBC_OFS_HALT, 32'h0); `CHK(q, 32'h1ff)
    // Stop waits for the running transfer, start clears
    stop_sw <= 1'b1; busy <= 1'b1; op_end <= 1'b1;
    repeat (8) @(posedge core_clk);
    `CHK(halt, 1'b0)
    busy <= 1'b0;
    repeat (6) @(posedge core_clk);
    `CHK({halt, stl}, 2'h3)
    stop_sw <= 1'b0; op_end <= 1'b0;
    repeat (6) @(posedge core_clk);
    `CHK({halt, stl, hl}, 11'h0)
    bus(1'b0, 5'h1c, 32'h0); `CHK(q, 32'h0)
    final_report();
  end

  // Watchdog well past the expected few hundred cycles
  initial
  begin
    #(20000 * 100);
    fail_count++;
    $display("Error %0t: timeout", $time);
    final_report();
  end
endmodule : kbc_top_tb
